// >>> can_error_diag_timestamp.sv
// can error counters, last-error diagnostics and bit time stamp counter.
// assumes a protocol core beside it that reports bit ticks, field starts,
// errors and frame outcomes, and an avalon-mm master for the registers.
//
// Operation
// RQ1: error counter report: receive tally in bits 15..8, transmit 7..0.
// RQ2: diagnostic report is read-only and all zero after reset.
// RQ3: bits 3..0 hold field code active when last error detected.
// RQ4: field codes 1101 dlc, 1110 data, 1111 checksum.
// RQ5: bits 9..4 bit position: load length-1, count down, capture.
// RQ6: bit 10 is one when transmitting at the error, else zero.
// RQ7: bit 11 set when a stuffing violation caused the error.
// RQ8: bit 12 flags an invalid checksum.
// RQ9: bit 13 captures the sampled receive pin level at the error.
// RQ10: bit 14 captures the transmit pin level at the error.
// RQ11: as receiver, drive bus only in acknowledge slot or error flag.
// RQ12: read-only free-running 16-bit counter, one step per can bit.
// RQ13: time stamp counter starts from zero after hardware reset.
// RQ14: stamp-reset enable clears counter when buffer 0 completes transfer.
// RQ15: after good frame, copy counter into that buffer's stamp.
// RQ16: software configures timing, buffers, masks before setting enable.
// RQ17: software checks no transmission pending before disabling.
// RQ18: disabling the controller also disables the receive pin.
// RQ19: configuration contents kept unchanged through reduced power.
// RQ20: software sets external wake input to falling edge.
// RQ21: software re-enables controller after wake-up if disabled.
// RQ22: transmit and receive pin polarity selected by two config bits.
// RQ23: with irq enabled, any tally change sets pending and requests.
// RQ24: each new error overwrites every diagnostic field.
// RQ25: tallies follow can fault confinement increments and decrements.
module can_error_diag_timestamp
    import can_diag_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // can pins
    output logic             bus_transmit_pin,
    input  wire logic        bus_receive_pin,
    // protocol core side
    output logic             ctrl_enable,
    output logic             rx_level,
    input  wire logic        core_tx_level,
    input  wire logic        core_sending,
    input  wire logic        core_ack_slot,
    input  wire logic        core_error_flag,
    input  wire logic        bit_tick,
    input  wire logic        field_start,
    input  wire logic [3:0]  field_code,
    input  wire logic [6:0]  field_length,
    input  wire logic        error_detect,
    input  wire logic        error_stuff,
    input  wire logic        error_crc,
    input  wire logic        rx_fault_small,
    input  wire logic        rx_fault_large,
    input  wire logic        tx_fault_large,
    input  wire logic        rx_frame_ok,
    input  wire logic        tx_frame_ok,
    input  wire logic        bus_off_recover,
    input  wire logic        frame_done,
    input  wire logic [3:0]  frame_buffer,
    // time stamp write into a message buffer
    output logic             stamp_write,
    output logic      [3:0]  stamp_buffer,
    output logic      [15:0] stamp_value,
    // error interrupt request
    output logic             error_irq
);

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [CFG_WIDTH-1:0] global_configuration;
    logic                 error_irq_enable;
    logic                 error_irq_pending;
    logic [7:0]           rx_fault_tally;
    logic [7:0]           tx_fault_tally;
    logic [7:0]           next_rx_tally;
    logic [7:0]           next_tx_tally;
    logic [15:0]          error_diagnostic_report;
    logic [15:0]          bit_time_stamp_counter;
    logic [5:0]           bit_position;
    logic [3:0]           current_field;
    logic                 bus_ack;
    logic [31:0]          next_readdata;

    logic                 wr_go;
    logic                 enabled;
    logic                 tx_pol;
    logic                 rx_pol;
    logic                 drive_level;
    logic [15:0]          error_counter_report;

    assign enabled = global_configuration[CFG_ENABLE_BIT];
    assign tx_pol  = global_configuration[CFG_TX_POL_BIT];
    assign rx_pol  = global_configuration[CFG_RX_POL_BIT];
    assign ctrl_enable = enabled;

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, then data and write both land
    assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
    assign wr_go = avs_write & bus_ack & clk_en;

    // ack toggles so a held request completes once every two edges
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_ack <= 1'b0;
        end else if (clk_en) begin
            bus_ack <= (avs_read | avs_write) & ~bus_ack;
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            OFS_GLOBAL_CONFIG:
                next_readdata[CFG_WIDTH-1:0] = global_configuration;
            // RQ1: counter report read
            OFS_ERR_COUNTER:
                next_readdata[15:0] = error_counter_report;
            // RQ2: diagnostic read only
            OFS_ERR_DIAG:
                next_readdata[15:0] = error_diagnostic_report;
            // RQ12: stamp read only
            OFS_STAMP_COUNTER:
                next_readdata[15:0] = bit_time_stamp_counter;
            OFS_ERR_IRQ_CONTROL: begin
                next_readdata[IRQ_ENABLE_BIT]  = error_irq_enable;
                next_readdata[IRQ_PENDING_BIT] = error_irq_pending;
            end
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // read data captured at the edge before waitrequest drops
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en && avs_read && !bus_ack) begin
            avs_readdata <= next_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration writes
    // RQ19: kept contents only a write or reset changes them
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            global_configuration <= CFG_RESET;
            error_irq_enable     <= 1'b0;
        end else if (wr_go) begin
            if (avs_address == OFS_GLOBAL_CONFIG) begin
                global_configuration <= avs_writedata[CFG_WIDTH-1:0];
            end
            if (avs_address == OFS_ERR_IRQ_CONTROL) begin
                error_irq_enable <= avs_writedata[IRQ_ENABLE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins
    // RQ18: receive pin ignored while disabled
    // RQ22: receive polarity select
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_level <= LEVEL_RECESSIVE;
        end else if (clk_en) begin
            rx_level <= enabled ? (bus_receive_pin ^ rx_pol) : LEVEL_RECESSIVE;
        end
    end

    // RQ11: receiver only drives ack slot and error flag
    always_comb begin
        drive_level = LEVEL_RECESSIVE;
        if (enabled && (core_sending || core_ack_slot || core_error_flag)) begin
            drive_level = core_tx_level;
        end
    end

    // RQ22: transmit polarity select, registered so the pin is glitch free
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_transmit_pin <= LEVEL_RECESSIVE;
        end else if (clk_en) begin
            bus_transmit_pin <= drive_level ^ tx_pol;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault tallies
    // RQ25: fault confinement arithmetic, saturating at the top
    always_comb begin
        next_rx_tally = rx_fault_tally;
        next_tx_tally = tx_fault_tally;
        if (bus_off_recover) begin
            next_rx_tally = TALLY_RESET;
            next_tx_tally = TALLY_RESET;
        end else begin
            if (rx_fault_large) begin
                next_rx_tally = (rx_fault_tally > TALLY_MAX - TALLY_STEP_LARGE)
                              ? TALLY_MAX : rx_fault_tally + TALLY_STEP_LARGE;
            end else if (rx_fault_small) begin
                next_rx_tally = (rx_fault_tally == TALLY_MAX)
                              ? TALLY_MAX : rx_fault_tally + TALLY_STEP_SMALL;
            end else if (rx_frame_ok) begin
                if (rx_fault_tally > RX_PASSIVE_EDGE) begin
                    next_rx_tally = RX_REENTRY_VALUE;
                end else if (rx_fault_tally != TALLY_RESET) begin
                    next_rx_tally = rx_fault_tally - TALLY_STEP_SMALL;
                end
            end
            if (tx_fault_large) begin
                next_tx_tally = (tx_fault_tally > TALLY_MAX - TALLY_STEP_LARGE)
                              ? TALLY_MAX : tx_fault_tally + TALLY_STEP_LARGE;
            end else if (tx_frame_ok && tx_fault_tally != TALLY_RESET) begin
                next_tx_tally = tx_fault_tally - TALLY_STEP_SMALL;
            end
        end
    end

    // tally registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_fault_tally <= TALLY_RESET;
            tx_fault_tally <= TALLY_RESET;
        end else if (clk_en) begin
            rx_fault_tally <= next_rx_tally;
            tx_fault_tally <= next_tx_tally;
        end
    end

    // RQ1: report packing
    assign error_counter_report = {rx_fault_tally, tx_fault_tally};

    ////////////////////////////////////////////////////////////////////////
    // error interrupt
    // RQ23: tally change sets pending while irq enabled; a set beats a same-cycle clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            error_irq_pending <= 1'b0;
        end else if (clk_en) begin
            if (error_irq_enable && (next_rx_tally != rx_fault_tally ||
                                     next_tx_tally != tx_fault_tally)) begin
                error_irq_pending <= 1'b1;
            end else if (wr_go && avs_address == OFS_ERR_IRQ_CONTROL &&
                         avs_writedata[IRQ_PENDING_BIT]) begin
                error_irq_pending <= 1'b0;
            end
        end
    end

    assign error_irq = error_irq_pending & error_irq_enable;

    ////////////////////////////////////////////////////////////////////////
    // field tracking
    // RQ5: load length minus one, count down per bit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bit_position  <= 6'h00;
            current_field <= 4'h0;
        end else if (clk_en) begin
            if (field_start) begin
                bit_position  <= 6'(field_length - 7'h01);
                current_field <= field_code;
            end else if (bit_tick) begin
                bit_position  <= bit_position - 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // diagnostic capture
    // RQ24: every error rewrites the whole report
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            error_diagnostic_report <= DIAG_RESET;
        end else if (clk_en && error_detect) begin
            error_diagnostic_report <= DIAG_RESET;
            // RQ4: dlc, data and crc codes kept as the core gives them
            // RQ3: field code capture
            error_diagnostic_report[DIAG_CODE_LSB +: 4] <= current_field;
            // RQ5: bit position capture
            error_diagnostic_report[DIAG_POS_LSB +: 6]  <= bit_position;
            // RQ6: transmitter or receiver
            error_diagnostic_report[DIAG_SENDING_BIT]   <= core_sending;
            // RQ7: stuffing violation
            error_diagnostic_report[DIAG_STUFF_BIT]     <= error_stuff;
            // RQ8: checksum invalid
            error_diagnostic_report[DIAG_CRC_BIT]       <= error_crc;
            // RQ9: sampled receive level
            error_diagnostic_report[DIAG_LINE_BIT]      <= rx_level;
            // RQ10: transmit pin level
            error_diagnostic_report[DIAG_DRIVE_BIT]     <= bus_transmit_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // time stamp
    // RQ13: zero from reset; RQ14: buffer 0 clear wins over counting
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bit_time_stamp_counter <= STAMP_RESET;
        end else if (clk_en) begin
            if (global_configuration[CFG_STAMP_RST_BIT] && frame_done &&
                frame_buffer == 4'h0) begin
                bit_time_stamp_counter <= STAMP_RESET;
            // RQ12: one step per recognised bit
            end else if (bit_tick) begin
                bit_time_stamp_counter <= bit_time_stamp_counter + 16'h0001;
            end
        end
    end

    // RQ15: stamp copied to the finishing buffer, value before any clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stamp_write  <= 1'b0;
            stamp_buffer <= 4'h0;
            stamp_value  <= STAMP_RESET;
        end else if (clk_en) begin
            stamp_write <= frame_done;
            if (frame_done) begin
                stamp_buffer <= frame_buffer;
                stamp_value  <= bit_time_stamp_counter;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_diag_code_capture: assert property ( // RQ3
        clk_en && error_detect && !field_start |=>
        error_diagnostic_report[3:0] == $past(current_field))
        else $error("field code not captured");

    a_position_load: assert property ( // RQ5
        clk_en && field_start |=>
        bit_position == 6'($past(field_length) - 7'h01))
        else $error("bit position not loaded");

    a_position_count: assert property ( // RQ5
        clk_en && !field_start && bit_tick |=>
        bit_position == $past(bit_position) - 6'h01)
        else $error("bit position not decremented");

    a_diag_sending: assert property ( // RQ6
        clk_en && error_detect |=>
        error_diagnostic_report[DIAG_SENDING_BIT] == $past(core_sending))
        else $error("sending flag wrong");

    a_diag_drive: assert property ( // RQ10
        clk_en && error_detect |=>
        error_diagnostic_report[DIAG_DRIVE_BIT] == $past(bus_transmit_pin))
        else $error("drive level wrong");

    a_receiver_quiet: assert property ( // RQ11
        clk_en && !core_sending && !core_ack_slot && !core_error_flag |=>
        bus_transmit_pin == (LEVEL_RECESSIVE ^ $past(tx_pol)))
        else $error("receiver drove the bus");

    a_stamp_step: assert property ( // RQ12
        clk_en && bit_tick && !frame_done |=>
        bit_time_stamp_counter == $past(bit_time_stamp_counter) + 16'h0001)
        else $error("stamp did not step");

    a_stamp_clear: assert property ( // RQ14
        clk_en && frame_done && frame_buffer == 4'h0 &&
        global_configuration[CFG_STAMP_RST_BIT] |=>
        bit_time_stamp_counter == STAMP_RESET)
        else $error("stamp not cleared");

    a_stamp_copy: assert property ( // RQ15
        clk_en && frame_done |=> stamp_write &&
        stamp_value == $past(bit_time_stamp_counter))
        else $error("stamp not copied");

    a_rx_disabled: assert property ( // RQ18
        clk_en && !enabled |=> rx_level == LEVEL_RECESSIVE)
        else $error("receive pin live while disabled");

    a_irq_on_change: assert property ( // RQ23
        clk_en && error_irq_enable && tx_fault_large &&
        !bus_off_recover && tx_fault_tally != TALLY_MAX |=> error_irq)
        else $error("tally change raised no irq");

    a_tx_penalty: assert property ( // RQ25
        clk_en && tx_fault_large && !bus_off_recover &&
        tx_fault_tally < 8'hF0 |=>
        tx_fault_tally == $past(tx_fault_tally) + TALLY_STEP_LARGE)
        else $error("transmit tally not raised by eight");

    c_error_captured: cover property (clk_en && error_detect && core_sending);
    c_buffer0_clear: cover property (
        clk_en && frame_done && frame_buffer == 4'h0 &&
        global_configuration[CFG_STAMP_RST_BIT]);
    c_irq_raised: cover property (!error_irq ##1 error_irq);
    c_rx_reentry: cover property (
        clk_en && rx_frame_ok && rx_fault_tally > RX_PASSIVE_EDGE);

endmodule // can_error_diag_timestamp

// >>> can_diag_pkg.sv
// constants for the can error, diagnostic and bit time stamp block.
// assumes a 32-bit avalon-mm slave port and a 20 MHz module clock.
package can_diag_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [4:0] OFS_GLOBAL_CONFIG   = 5'h00;
    localparam logic [4:0] OFS_ERR_COUNTER     = 5'h04;
    localparam logic [4:0] OFS_ERR_DIAG        = 5'h08;
    localparam logic [4:0] OFS_STAMP_COUNTER   = 5'h0C;
    localparam logic [4:0] OFS_ERR_IRQ_CONTROL = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // global_configuration fields
    localparam int CFG_ENABLE_BIT     = 0;
    localparam int CFG_STAMP_RST_BIT  = 1;
    localparam int CFG_TX_POL_BIT     = 2;
    localparam int CFG_RX_POL_BIT     = 3;
    localparam int CFG_WIDTH          = 4;
    localparam logic [3:0] CFG_RESET  = 4'h0;

    // error_irq_control fields
    localparam int IRQ_ENABLE_BIT     = 0;
    localparam int IRQ_PENDING_BIT    = 1;

    ////////////////////////////////////////////////////////////////////////
    // error_counter_report layout
    localparam int RX_TALLY_LSB       = 8;
    localparam int TX_TALLY_LSB       = 0;
    localparam logic [7:0] TALLY_RESET = 8'h00;

    // error_diagnostic_report layout
    localparam int DIAG_CODE_LSB      = 0;
    localparam int DIAG_POS_LSB       = 4;
    localparam int DIAG_SENDING_BIT   = 10;
    localparam int DIAG_STUFF_BIT     = 11;
    localparam int DIAG_CRC_BIT       = 12;
    localparam int DIAG_LINE_BIT      = 13;
    localparam int DIAG_DRIVE_BIT     = 14;
    localparam logic [15:0] DIAG_RESET = 16'h0000;

    // frame field codes that the core reports
    localparam logic [3:0] FIELD_DLC  = 4'hD;
    localparam logic [3:0] FIELD_DATA = 4'hE;
    localparam logic [3:0] FIELD_CRC  = 4'hF;

    // time stamp counter
    localparam logic [15:0] STAMP_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // fault confinement figures
    localparam logic [7:0] TALLY_STEP_SMALL = 8'h01;
    localparam logic [7:0] TALLY_STEP_LARGE = 8'h08;
    localparam logic [7:0] TALLY_MAX        = 8'hFF;
    localparam logic [7:0] RX_PASSIVE_EDGE  = 8'h7F;
    localparam logic [7:0] RX_REENTRY_VALUE = 8'h78;

    // pin level of a recessive bit before polarity is applied
    localparam logic LEVEL_RECESSIVE = 1'b1;

endpackage

// >>> can_xcvr_model.sv
// transceiver model on the far side of the can pins.
// assumes a dominant low bus with the pin polarity bits left clear.
module can_xcvr_model (
    input  wire logic clk_sys,
    input  wire logic txd,
    input  wire logic foreign_dominant,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ns;

    // wired-and bus: any node driving dominant pulls the line low
    always_ff @(posedge clk_sys) begin
        rxd <= txd & ~foreign_dominant;
    end
endmodule // can_xcvr_model

// >>> can_error_diag_timestamp_tb_top.sv
// self-checking bench for the error, diagnostic and time stamp block.
// assumes one 20 MHz clock and the transceiver model on the pins.
module can_error_diag_timestamp_tb_top
    import can_diag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys, rst, clk_en, avs_read, avs_write, bus_receive_pin;
    logic        core_tx_level, core_sending, core_ack_slot, core_error_flag;
    logic        bit_tick, field_start, error_detect, error_stuff, error_crc;
    logic        rx_fault_small, rx_fault_large, tx_fault_large, rx_frame_ok;
    logic        tx_frame_ok, bus_off_recover, frame_done, foreign_dominant;
    logic        avs_waitrequest, bus_transmit_pin, ctrl_enable, rx_level;
    logic        stamp_write, error_irq;
    logic [3:0]  field_code, frame_buffer, stamp_buffer;
    logic [6:0]  field_length;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    logic [15:0] stamp_value, ticks;
    int          mismatches, compares, cycles;

    can_error_diag_timestamp can_error_diag_timestamp_inst (.*);
    can_xcvr_model can_xcvr_model_inst (.clk_sys(clk_sys),
        .txd(bus_transmit_pin), .foreign_dominant(foreign_dominant),
        .rxd(bus_receive_pin));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the run needs well under a thousand cycles
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step();
        @(posedge clk_sys);
    endtask

    // drop every pulse input, then let one edge pass
    task automatic idle();
        {bit_tick, field_start, error_detect, error_stuff, error_crc,
         rx_fault_small, rx_fault_large, tx_fault_large, rx_frame_ok,
         tx_frame_ok, bus_off_recover, frame_done} <= '0;
        step();
    endtask

    // one avalon access; held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        logic wait_low;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        // sample before the edge, clear of the updates that it launches
        do begin
            @(negedge clk_sys);
            rdata = avs_readdata;
            wait_low = (avs_waitrequest === 1'b0);
            step();
        end while (!wait_low);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        step();
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [4:0] regs [4] = '{OFS_ERR_COUNTER, OFS_ERR_DIAG,
                                 OFS_STAMP_COUNTER, 5'h14};
        foreach (regs[i]) begin
            bus(1'b1, regs[i], 32'hFFFF);
            bus(1'b0, regs[i], 32'h0);
            chk("reset value", 32'h0, rdata);
        end
    endtask

    task automatic t_tally();
        bus(1'b1, OFS_ERR_IRQ_CONTROL, 32'h1);
        rx_fault_large <= 1'b1;
        tx_fault_large <= 1'b1;
        step();
        idle();
        bus(1'b0, OFS_ERR_COUNTER, 32'h0);
        chk("tallies", 32'h0808, rdata);
        chk("irq raised", 32'h1, 32'(error_irq));
        rx_frame_ok <= 1'b1;
        tx_frame_ok <= 1'b1;
        step();
        idle();
        bus(1'b0, OFS_ERR_COUNTER, 32'h0);
        chk("decrement", 32'h0707, rdata);
        // clear pending and disable; a later change must not pend
        bus(1'b1, OFS_ERR_IRQ_CONTROL, 32'h2);
        rx_fault_small <= 1'b1;
        step();
        idle();
        bus(1'b0, OFS_ERR_IRQ_CONTROL, 32'h0);
        chk("pending off", 32'h0, rdata);
        chk("irq off", 32'h0, 32'(error_irq));
        bus_off_recover <= 1'b1;
        step();
        idle();
    endtask

    task automatic t_diag(input logic [3:0] code, input logic [6:0] len,
                          input int n, input logic snd, stf, crc, dom);
        core_sending <= snd;
        foreign_dominant <= dom;
        field_code <= code;
        field_length <= len;
        field_start <= 1'b1;
        step();
        idle();
        bit_tick <= 1'b1;
        repeat (n) step();
        idle();
        ticks = ticks + 16'(n);
        error_detect <= 1'b1;
        error_stuff <= stf;
        error_crc <= crc;
        step();
        idle();
        bus(1'b0, OFS_ERR_DIAG, 32'h0);
        chk("diagnostic", {17'h0, 1'b1, ~dom, crc, stf, snd,
            6'(len - 7'd1 - 7'(n)), code}, rdata);
    endtask

    task automatic t_pins();
        core_sending <= 1'b0;
        core_tx_level <= 1'b0;
        repeat (4) step();
        chk("receiver idle", 32'h1, 32'(bus_transmit_pin));
        core_ack_slot <= 1'b1;
        repeat (4) step();
        chk("ack slot", 32'h0, 32'(bus_transmit_pin));
        core_ack_slot <= 1'b0;
        core_error_flag <= 1'b1;
        repeat (4) step();
        chk("error flag", 32'h0, 32'(bus_transmit_pin));
        core_error_flag <= 1'b0;
        core_tx_level <= 1'b1;
        bus(1'b1, OFS_GLOBAL_CONFIG, 32'h5);
        repeat (4) step();
        chk("tx inverted", 32'h0, 32'(bus_transmit_pin));
        chk("rx plain", 32'h0, 32'(rx_level));
        bus(1'b1, OFS_GLOBAL_CONFIG, 32'hD);
        repeat (4) step();
        chk("rx inverted", 32'h1, 32'(rx_level));
        bus(1'b1, OFS_GLOBAL_CONFIG, 32'h1);
    endtask

    task automatic t_stamp();
        bus(1'b0, OFS_STAMP_COUNTER, 32'h0);
        chk("bit count", 32'(ticks), rdata);
        frame_done <= 1'b1;
        frame_buffer <= 4'h3;
        step();
        frame_done <= 1'b0;
        @(negedge clk_sys);
        chk("stamp", {15'h3, ticks, 1'b1},
            {11'h0, stamp_buffer, stamp_value, stamp_write});
        step();
        bus(1'b1, OFS_GLOBAL_CONFIG, 32'h3);
        frame_done <= 1'b1;
        frame_buffer <= 4'h0;
        step();
        idle();
        bus(1'b0, OFS_STAMP_COUNTER, 32'h0);
        chk("stamp cleared", 32'h0, rdata);
    endtask

    task automatic t_power();
        // no transmission pending before the controller goes down
        core_sending <= 1'b0;
        bus(1'b1, OFS_GLOBAL_CONFIG, 32'hE);
        foreign_dominant <= 1'b1; // dominant pulls low
        repeat (4) step();
        chk("rx gated", 32'h1, 32'(rx_level));
        clk_en <= 1'b0;
        repeat (5) step();
        clk_en <= 1'b1;
        bus(1'b0, OFS_GLOBAL_CONFIG, 32'h0);
        chk("config kept", 32'hE, rdata);
        // wake-up: software brings the controller back
        bus(1'b1, OFS_GLOBAL_CONFIG, 32'h1);
        foreign_dominant <= 1'b0;
        step();
        chk("re-enabled", 32'h1, 32'(ctrl_enable));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {avs_read, avs_write, core_sending, core_ack_slot, core_error_flag,
         bit_tick, field_start, error_detect, error_stuff, error_crc,
         rx_fault_small, rx_fault_large, tx_fault_large, rx_frame_ok,
         tx_frame_ok, bus_off_recover, frame_done, foreign_dominant} = '0;
        {field_code, frame_buffer, field_length, avs_address} = '0;
        avs_writedata = '0;
        ticks = '0;
        {mismatches, compares, cycles} = '0;
        core_tx_level = 1'b1;
        clk_en = 1'b1;
        rst = 1'b1;
        repeat (6) step();
        rst <= 1'b0;
        step();
        t_reset();
        // timing, buffers and masks live elsewhere; enable comes last
        bus(1'b1, OFS_GLOBAL_CONFIG, 32'h1);
        t_tally();
        t_diag(FIELD_DLC, 7'd4, 2, 1'b1, 1'b1, 1'b0, 1'b0);
        t_diag(FIELD_DATA, 7'd64, 7, 1'b0, 1'b0, 1'b1, 1'b1);
        t_diag(FIELD_CRC, 7'd15, 14, 1'b1, 1'b0, 1'b1, 1'b0);
        t_pins();
        t_stamp();
        t_power();
        give_verdict();
    end
endmodule // can_error_diag_timestamp_tb_top
